// *** design/rtc_digital_calibration.sv ***
// periodic counter correction of the hundredths clock input
`timescale 1ns/100ps
`default_nettype none

module rtc_digital_calibration (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       oscTick,   // one pulse per osc cycle
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStb,
  input  wire logic       regRdStb,
  output logic      [7:0] regRdData,
  output logic            irqTestOut, // interrupt/test pin level
  output logic            hundTick,   // corrected 100 Hz pulse
  output logic            secTick     // end of a second
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]       digCal_ff;    // digital_calibration
  logic             oscHalt_ff;   // osc_halt
  logic [7:0]       rdData_ff;    // read data, one cycle
  logic [rtc_cal_pkg::PRE_W-1:0] pre_ff; // 32768 Hz to 512 Hz
  logic             tick512;      // 512 Hz stage pulse
  logic [9:0]       inCnt_ff;     // inputs seen this second
  logic [9:0]       acc_ff;       // pulse accumulator
  logic [9:0]       period;       // inputs per second
  logic [9:0]       accSum;       // accumulator plus step
  logic             pulseNow;     // corrected pulse due
  logic             secEnd;       // last input of a second
  logic             hund_ff;      // registered 100 Hz pulse
  logic             sec_ff;       // registered second pulse
  logic [3:0]       tenths_ff;    // bcd tenths
  logic [3:0]       hundths_ff;   // bcd hundredths
  logic [9:0]       cycSec_ff;    // second within cycle
  logic [9:0]       cycLast;      // last second of cycle
  logic             cycWrap;      // cycle completes now
  logic [4:0]       actMag_ff;    // magnitude in force
  logic             actSign_ff;   // sign in force
  logic             corrActive;   // this second is corrected
  logic             testMode;     // 512 Hz on the pin
  logic             irq_ff;       // pin level
  logic [6:0]       pulseCnt_ff;  // pulses this second, check
  logic [6:0]       oscSeen_ff;   // osc ticks since 512 Hz tick

  // ------------------------------------------------------------
  // register write port
  // ------------------------------------------------------------
  // calibration byte stored whole; the divider reads it only
  // at cycle start, so a write mid-cycle is harmless
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      digCal_ff <= rtc_cal_pkg::DIGCAL_RESET;
    end else if (regWrStb &&
                 regAddr == rtc_cal_pkg::ADDR_DIGCAL) begin
      digCal_ff <= regWrData;
    end
  end

  // oscillator halt bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oscHalt_ff <= rtc_cal_pkg::HALT_RESET;
    end else if (regWrStb &&
                 regAddr == rtc_cal_pkg::ADDR_HALT) begin
      oscHalt_ff <= regWrData[rtc_cal_pkg::HALT_BIT];
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  // data stand only in the cycle after the strobe, else zero;
  // unmapped addresses read zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= 8'h00;
    end else if (regRdStb) begin
      unique case (regAddr)
        rtc_cal_pkg::ADDR_FRACTION: begin
          rdData_ff <= {tenths_ff, hundths_ff};
        end
        rtc_cal_pkg::ADDR_HALT: begin
          rdData_ff <= {oscHalt_ff, 7'h00};
        end
        rtc_cal_pkg::ADDR_DIGCAL: begin
          rdData_ff <= digCal_ff;
        end
        rtc_cal_pkg::ADDR_CALSTAT: begin
          rdData_ff <= {1'b0, corrActive, actSign_ff, actMag_ff};
        end
        default: begin
          rdData_ff <= 8'h00;
        end
      endcase
    end else begin
      rdData_ff <= 8'h00;
    end
  end

  assign regRdData = rdData_ff;

  // ------------------------------------------------------------
  // 512 Hz prescaler
  // ------------------------------------------------------------
  // runs ahead of the correction stage, so the test pin never
  // sees a stretched or shortened second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_ff <= '0;
    end else if (oscTick && !oscHalt_ff) begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // one pulse per 64 oscillator cycles
  assign tick512 = oscTick && !oscHalt_ff && (&pre_ff);

  // ------------------------------------------------------------
  // calibration divider
  // ------------------------------------------------------------
  // inputs per second chosen by the settings in force
  always_comb begin
    if (!corrActive) begin
      period = rtc_cal_pkg::PER_NORMAL;
    end else if (actSign_ff) begin
      period = rtc_cal_pkg::PER_FAST;
    end else begin
      period = rtc_cal_pkg::PER_SLOW;
    end
  end

  // evenly spread pulses: add 100 per input, emit on overflow;
  // the sum returns to zero exactly at the second boundary
  assign accSum   = acc_ff + rtc_cal_pkg::PULSES_PER_SEC;
  assign pulseNow = tick512 && (accSum >= period);
  assign secEnd   = tick512 && (inCnt_ff == period - 10'd1);

  // accumulator
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
    end else if (secEnd) begin
      acc_ff <= '0;
    end else if (tick512) begin
      acc_ff <= pulseNow ? accSum - period : accSum;
    end
  end

  // input count within the second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      inCnt_ff <= '0;
    end else if (secEnd) begin
      inCnt_ff <= '0;
    end else if (tick512) begin
      inCnt_ff <= inCnt_ff + 10'd1;
    end
  end

  // registered strobes out
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hund_ff <= 1'b0;
      sec_ff  <= 1'b0;
    end else begin
      hund_ff <= pulseNow;
      sec_ff  <= secEnd;
    end
  end

  assign hundTick = hund_ff;
  assign secTick  = sec_ff;

  // ------------------------------------------------------------
  // fraction-of-seconds counter
  // ------------------------------------------------------------
  // bcd tenths and hundredths counted by the corrected pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tenths_ff  <= 4'h0;
      hundths_ff <= 4'h0;
    end else if (hund_ff) begin
      if (hundths_ff == 4'h9) begin
        hundths_ff <= 4'h0;
        tenths_ff  <= (tenths_ff == 4'h9) ? 4'h0 : tenths_ff + 4'h1;
      end else begin
        hundths_ff <= hundths_ff + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // correction cycle
  // ------------------------------------------------------------
  // 480 s or 960 s; each corrected second moves 1/512 s, which
  // gives the per-step ppm figure of the sign
  assign cycLast = actSign_ff ? rtc_cal_pkg::CYC_POS_LAST
                              : rtc_cal_pkg::CYC_NEG_LAST;
  assign cycWrap = secEnd && (cycSec_ff == cycLast);

  // first N seconds of the cycle; zero never corrects
  assign corrActive = (actMag_ff != 5'd0) &&
                      (cycSec_ff < {5'd0, actMag_ff});

  // second counter within the cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cycSec_ff <= '0;
    end else if (cycWrap) begin
      cycSec_ff <= '0;
    end else if (secEnd) begin
      cycSec_ff <= cycSec_ff + 10'd1;
    end
  end

  // settings copied only when a cycle ends; software should
  // still wait a full cycle between changes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      actMag_ff  <= '0;
      actSign_ff <= 1'b0;
    end else if (cycWrap) begin
      actMag_ff  <= digCal_ff[rtc_cal_pkg::MAG_LSB +:
                              rtc_cal_pkg::MAG_W];
      actSign_ff <= digCal_ff[rtc_cal_pkg::SIGN_BIT];
    end
  end

  // ------------------------------------------------------------
  // interrupt/test pin
  // ------------------------------------------------------------
  // taken from the raw prescaler, never the corrected divider
  assign testMode = digCal_ff[rtc_cal_pkg::FT_BIT] &&
                    digCal_ff[rtc_cal_pkg::OUT_BIT] && !oscHalt_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (testMode) begin
      irq_ff <= pre_ff[rtc_cal_pkg::PRE_W-1];
    end else begin
      irq_ff <= digCal_ff[rtc_cal_pkg::OUT_BIT];
    end
  end

  assign irqTestOut = irq_ff;

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  // pulses emitted so far in the current second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulseCnt_ff <= '0;
    end else if (secEnd) begin
      pulseCnt_ff <= '0;
    end else if (pulseNow) begin
      pulseCnt_ff <= pulseCnt_ff + 7'd1;
    end
  end

  // oscillator ticks seen since the last 512 Hz tick; kept apart
  // from the prescaler so the stage check is not circular
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oscSeen_ff <= '0;
    end else if (tick512) begin
      oscSeen_ff <= '0;
    end else if (oscTick && !oscHalt_ff) begin
      oscSeen_ff <= oscSeen_ff + 7'd1;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_stage_rate:
  assert property (@(posedge ref_clk) disable iff (rst)
    tick512 |-> oscTick && !oscHalt_ff && (oscSeen_ff == 7'd63))
    else $error("512 Hz stage not every 64 osc ticks");

  a_hundred_per_sec:
  assert property (@(posedge ref_clk) disable iff (rst)
    secEnd |-> (pulseCnt_ff + {6'd0, pulseNow}) == 7'd100)
    else $error("second did not hold 100 pulses");

  a_normal_ratio:
  assert property (@(posedge ref_clk) disable iff (rst)
    (secEnd && actMag_ff == 5'd0) |-> inCnt_ff == 10'd511)
    else $error("zero magnitude altered the ratio");

  a_fast_ratio:
  assert property (@(posedge ref_clk) disable iff (rst)
    (secEnd && corrActive && actSign_ff) |-> inCnt_ff == 10'd510)
    else $error("positive second not 511 inputs");

  a_slow_ratio:
  assert property (@(posedge ref_clk) disable iff (rst)
    (secEnd && corrActive && !actSign_ff) |-> inCnt_ff == 10'd512)
    else $error("negative second not 513 inputs");

  a_first_seconds:
  assert property (@(posedge ref_clk) disable iff (rst)
    corrActive |-> cycSec_ff < {5'd0, actMag_ff})
    else $error("correction outside first seconds");

  a_cycle_length:
  assert property (@(posedge ref_clk) disable iff (rst)
    cycSec_ff <= (actSign_ff ? 10'd479 : 10'd959))
    else $error("cycle longer than its length");

  a_hund_count:
  assert property (@(posedge ref_clk) disable iff (rst)
    (hund_ff && hundths_ff != 4'h9) |=>
      hundths_ff == $past(hundths_ff) + 4'h1)
    else $error("hundredths did not advance");

  a_load_at_wrap:
  assert property (@(posedge ref_clk) disable iff (rst)
    ($changed(actMag_ff) || $changed(actSign_ff)) |-> $past(cycWrap))
    else $error("settings changed inside a cycle");

  a_test_pin:
  assert property (@(posedge ref_clk) disable iff (rst)
    $past(testMode) |-> irqTestOut == $past(pre_ff[5]))
    else $error("test pin not following 512 Hz stage");

endmodule

`default_nettype wire

// *** design/rtc_cal_pkg.sv ***
// constants for the periodic counter correction block
package rtc_cal_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_FRACTION = 8'h00; // tenths/hundredths
  localparam logic [7:0] ADDR_HALT     = 8'h01; // oscillator halt
  localparam logic [7:0] ADDR_DIGCAL   = 8'h08; // digital_calibration
  localparam logic [7:0] ADDR_CALSTAT  = 8'h20; // correction status

  localparam int MAG_LSB   = 0; // cal_magnitude low bit
  localparam int MAG_W     = 5; // cal_magnitude width
  localparam int SIGN_BIT  = 5; // cal_sign
  localparam int FT_BIT    = 6; // freq_test_select
  localparam int OUT_BIT   = 7; // output level
  localparam int HALT_BIT  = 7; // osc_halt in ADDR_HALT
  localparam int ACT_BIT   = 6; // correction active, status

  localparam logic [7:0] DIGCAL_RESET = 8'h00;
  localparam logic       HALT_RESET   = 1'b0;

  // ------------------------------------------------------------
  // divider chain
  // ------------------------------------------------------------
  localparam int OSC_HZ      = 32768;
  localparam int STAGE_HZ    = 512;
  localparam int PRE_DIV     = OSC_HZ / STAGE_HZ; // 64
  localparam int PRE_W       = 6;
  localparam logic [9:0] PULSES_PER_SEC = 10'd100;
  localparam logic [9:0] PER_NORMAL     = 10'd512;
  localparam logic [9:0] PER_FAST       = 10'd511;
  localparam logic [9:0] PER_SLOW       = 10'd513;
  localparam logic [6:0] HUND_LAST      = 7'd99;

  // ------------------------------------------------------------
  // correction cycle
  // ------------------------------------------------------------
  localparam int SEC_PER_MIN = 60;
  localparam int CYC_POS_MIN = 8;
  localparam int CYC_NEG_MIN = 16;
  localparam logic [9:0] CYC_POS_LAST =
    10'(CYC_POS_MIN * SEC_PER_MIN - 1);
  localparam logic [9:0] CYC_NEG_LAST =
    10'(CYC_NEG_MIN * SEC_PER_MIN - 1);

endpackage

// *** test/rtc_digital_calibration_test.sv ***
// self-checking bench for the periodic counter correction block
`timescale 1ns/100ps
`default_nettype none

module rtc_digital_calibration_test;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic       ref_clk   = 1'b0;  // 10 MHz bench clock
  logic       rst       = 1'b1;  // held high at start
  logic       oscTick   = 1'b1;  // every cycle: shortest second
  logic [7:0] regAddr   = 8'h00; // register address
  logic [7:0] regWrData = 8'h00; // write data
  logic       regWrStb  = 1'b0;  // write strobe
  logic       regRdStb  = 1'b0;  // read strobe
  logic [7:0] regRdData;         // read data, one cycle late
  logic       irqTestOut;        // test pin level
  logic       hundTick;          // corrected 100 Hz pulse
  logic       secTick;           // end of second pulse
  int         badCount       = 0; // mismatches
  int         samplesChecked = 0; // comparisons made
  logic [7:0] rdVal;              // last value read

  always #50 ref_clk = ~ref_clk;

  rtc_digital_calibration u_dut (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .oscTick    (oscTick),
    .regAddr    (regAddr),
    .regWrData  (regWrData),
    .regWrStb   (regWrStb),
    .regRdStb   (regRdStb),
    .regRdData  (regRdData),
    .irqTestOut (irqTestOut),
    .hundTick   (hundTick),
    .secTick    (secTick)
  );

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  // the single place where the run ends
  task automatic endSim();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // case equality so an unknown never matches
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ------------------------------------------------------------
  // register bus tasks
  // ------------------------------------------------------------
  // one-cycle write strobe beside address and data
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrStb  <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, then return to 0
  task automatic regRead(input logic [7:0] a);
    @(posedge ref_clk);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1;
    rdVal = regRdData;
    @(posedge ref_clk);
    #1;
    chk("read data cleared", 16'h0000, {8'h00, regRdData});
  endtask

  // counts pin transitions over a number of cycles
  task automatic countToggles(input int n, output int t);
    logic last;
    t = 0;
    @(posedge ref_clk);
    #1;
    last = irqTestOut;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      if (irqTestOut !== last) t++;
      last = irqTestOut;
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int tg;
    int cyc;
    int hc;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values and access kinds
    regRead(rtc_cal_pkg::ADDR_DIGCAL);
    chk("digcal reset", 16'h0000, {8'h00, rdVal});
    regRead(rtc_cal_pkg::ADDR_HALT);
    chk("halt reset", 16'h0000, {8'h00, rdVal});
    regRead(8'h3c);
    chk("unmapped read", 16'h0000, {8'h00, rdVal});
    regWrite(8'h3c, 8'hff);
    // output level alone drives the pin
    regWrite(rtc_cal_pkg::ADDR_DIGCAL, 8'h80);
    @(posedge ref_clk);
    #1;
    chk("pin high", 16'h0001, {15'h0, irqTestOut});
    // test select without level: no toggling
    regWrite(rtc_cal_pkg::ADDR_DIGCAL, 8'h40);
    countToggles(200, tg);
    chk("ft only toggles", 16'h0000, 16'(tg));
    // test mode: 512 Hz square, 32 cycles per half period
    regWrite(rtc_cal_pkg::ADDR_DIGCAL, 8'hc0);
    repeat (4) @(posedge ref_clk);
    countToggles(640, tg);
    chk("test toggles", 16'd20, 16'(tg));
    // calibration change leaves the test frequency untouched
    regWrite(rtc_cal_pkg::ADDR_DIGCAL, 8'hff);
    countToggles(640, tg);
    chk("test toggles cal", 16'd20, 16'(tg));
    // no oscillator ticks: prescaler and pin stand still
    oscTick <= 1'b0;
    countToggles(200, tg);
    chk("no osc toggles", 16'h0000, 16'(tg));
    @(posedge ref_clk);
    oscTick <= 1'b1;
    regRead(rtc_cal_pkg::ADDR_DIGCAL);
    chk("digcal readback", 16'h00ff, {8'h00, rdVal});
    // oscillator halt freezes the test toggle
    regWrite(rtc_cal_pkg::ADDR_HALT, 8'hff);
    regRead(rtc_cal_pkg::ADDR_HALT);
    chk("halt readback", 16'h0080, {8'h00, rdVal});
    countToggles(200, tg);
    chk("halted toggles", 16'h0000, 16'(tg));
    regWrite(rtc_cal_pkg::ADDR_HALT, 8'h00);
    // magnitude 31 positive, but this cycle stays uncorrected
    regWrite(rtc_cal_pkg::ADDR_DIGCAL, 8'h3f);
    regRead(rtc_cal_pkg::ADDR_CALSTAT);
    chk("status first cycle", 16'h0000, {8'h00, rdVal});
    // align to a second boundary, bounded
    cyc = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end while (secTick !== 1'b1 && cyc < 40000);
    if (cyc >= 40000) begin
      badCount++;
      $display("[FAIL] second boundary expected seen none");
    end else begin
      // one full second: 512 ticks of 64 cycles, 100 hundredths
      cyc = 0;
      hc = 0;
      do begin
        @(posedge ref_clk);
        #1;
        cyc++;
        if (hundTick === 1'b1) hc++;
      end while (secTick !== 1'b1 && cyc < 40000);
      chk("second length", 16'h8000, 16'(cyc));
      chk("hundredths per second", 16'd100, 16'(hc));
      regRead(rtc_cal_pkg::ADDR_CALSTAT);
      chk("status still idle", 16'h0000, {8'h00, rdVal});
      // ten more pulses from a whole second carry into the tenths
      cyc = 0;
      hc = 0;
      while (hc < 10 && cyc < 40000) begin
        @(posedge ref_clk);
        #1;
        cyc++;
        if (hundTick === 1'b1) hc++;
      end
      regRead(rtc_cal_pkg::ADDR_FRACTION);
      chk("fraction tenths", 16'h0010, {8'h00, rdVal});
    end
    endSim();
  end

endmodule

`default_nettype wire
